// File: rtl/sysbus_ctrl_status_irq_regs.sv
`timescale 1ns/1ps
module sysbus_ctrl_status_irq_regs
  import sysbus_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic masterIsUser,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic [MODE_W-1:0] modePins,
  input wire logic configuring,
  input wire logic [1:0] cfgErrCode,
  input wire logic initPad,
  input wire logic donePad,
  input wire logic cfgDataLost,
  input wire logic [1:0] cfgBusErr,
  input wire logic [31:0] cfgBusErrAddr,
  input wire logic readbackRangeError,
  input wire logic [1:0] cfgWriteSize,
  input wire logic blockRamInitError,
  input wire logic auxBlockInitError,
  input wire logic readbackPending,
  input wire logic cfgWriteReady,
  input wire logic serdesIrq,
  input wire logic hostPortIrq,
  input wire logic cfgDataReq,
  input wire logic userMasterIrq,
  input wire logic userSlaveIrq,
  input wire logic userInterruptIn,
  output logic [7:0] busRdata,
  output logic busRvalid,
  output logic userMasterBusLock,
  output logic hostPortBusLock,
  output logic reconfigRequest,
  output logic [MODE_W-1:0] reconfigMode,
  output logic chainConfigEnable,
  output logic globalSetReset,
  output logic hostWriteParityCheck,
  output logic fabricPadAccessEnable,
  output logic [31:0] firstBusErrAddr,
  output logic userInterruptOut
);
  typedef struct packed {
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] userEn;
    logic reconfig;
    logic modeTaken;
    logic [MODE_W-1:0] mode;
    logic [1:0] prevErr;
    logic errSeen;
    logic [1:0] busErr;
    logic [31:0] errAddr;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;
  logic [7:0] cause;
  logic [7:0] causeSet;
  logic [7:0] causeClr;
  logic [7:0] cfgStat;
  logic [7:0] xferStat;
  logic wrCtrl2;
  logic wrCtrl3;
  logic wrCause;
  logic wrUserEn;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] t);
    hit = (a == t);
  endfunction

  assign wrCtrl2 = busWrite && hit(busAddr, ADDR_CTRL2);
  assign wrCtrl3 = busWrite && hit(busAddr, ADDR_CTRL3);
  assign wrCause = busWrite && hit(busAddr, ADDR_CAUSE);
  assign wrUserEn = busWrite && hit(busAddr, ADDR_USER_EN);

  always_comb begin
    causeSet = 8'h00;
    causeSet[B_C_SERDES] = serdesIrq;
    causeSet[B_C_HOST] = hostPortIrq;
    causeSet[B_C_CFGERR] = configuring && (cfgErrCode != s_q.prevErr);
    causeSet[B_C_CFGDATA] = cfgDataReq;
    causeSet[B_C_UMASTER] = userMasterIrq;
    causeSet[B_C_USLAVE] = userSlaveIrq;
    causeSet[B_C_USER] = userInterruptIn;
  end

  assign causeClr = wrCause ? (busWdata & CAUSE_MASK) : 8'h00;

  sticky_flags #(
    .WIDTH(8)
  ) u_cause (
    .clk(clk),
    .rst(rst),
    .setFlags(causeSet),
    .clearFlags(causeClr),
    .flags(cause)
  );

  always_comb begin
    cfgStat = 8'h00;
    cfgStat[7:6] = cfgErrCode;
    cfgStat[5] = initPad;
    cfgStat[4] = donePad;
    cfgStat[3] = cfgDataLost;
    cfgStat[2:1] = s_q.busErr;
    cfgStat[0] = readbackRangeError;
  end

  always_comb begin
    xferStat = 8'h00;
    xferStat[7:6] = cfgWriteSize;
    xferStat[5] = blockRamInitError;
    xferStat[4] = auxBlockInitError;
    xferStat[1] = readbackPending;
    xferStat[0] = cfgWriteReady;
  end

  always_comb begin
    s_d = s_q;
    s_d.rvalid = busRead;
    s_d.prevErr = cfgErrCode;
    // catch mode once after reset release
    if (!s_q.modeTaken) begin
      s_d.modeTaken = 1'b1;
      s_d.mode = modePins;
    end
    if (wrCtrl2) begin
      s_d.ctrl2 = (s_q.ctrl2 & ~CTRL2_ANY_MASK) |
                  (busWdata & CTRL2_ANY_MASK);
      if (masterIsUser) begin
        s_d.ctrl2[B_UM_LOCK] = busWdata[B_UM_LOCK];
      end
      if (!masterIsUser) begin
        s_d.ctrl2[B_HP_LOCK] = busWdata[B_HP_LOCK];
      end
    end
    if (wrCtrl3) begin
      s_d.ctrl3 = busWdata & CTRL3_MASK;
    end
    if (wrUserEn && masterIsUser) begin
      s_d.userEn = busWdata & USER_EN_MASK;
    end
    // request follows bits 4 and 5
    s_d.reconfig = s_d.ctrl2[B_UM_REQ] | s_d.ctrl2[B_HP_REQ];
    if (!s_q.errSeen && (cfgBusErr != 2'b00)) begin
      s_d.errSeen = 1'b1;
      s_d.busErr = cfgBusErr;
      s_d.errAddr = cfgBusErrAddr;
    end
    s_d.irq = |(cause & s_q.userEn);
    s_d.rdata = 8'h00;
    if (busRead) begin
      case (busAddr)
        ADDR_CTRL2: s_d.rdata = s_q.ctrl2;
        ADDR_CTRL3: s_d.rdata = s_q.ctrl3;
        ADDR_CFG_STAT: s_d.rdata = cfgStat;
        ADDR_XFER_STAT: s_d.rdata = xferStat;
        ADDR_CAUSE: s_d.rdata = cause;
        ADDR_USER_EN: s_d.rdata = s_q.userEn;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl2 <= REG_RST;
      s_q.ctrl3 <= REG_RST;
      s_q.userEn <= REG_RST;
      s_q.errAddr <= ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign busRdata = s_q.rdata;
  assign busRvalid = s_q.rvalid;
  assign userMasterBusLock = s_q.ctrl2[B_UM_LOCK];
  assign hostPortBusLock = s_q.ctrl2[B_HP_LOCK];
  assign reconfigRequest = s_q.reconfig;
  assign reconfigMode = s_q.mode;
  assign chainConfigEnable = s_q.ctrl2[B_CHAIN];
  assign globalSetReset = s_q.ctrl2[B_GSR];
  assign hostWriteParityCheck = s_q.ctrl3[B_PAR_CHK];
  assign fabricPadAccessEnable = s_q.ctrl3[B_PAD_EN];
  assign firstBusErrAddr = s_q.errAddr;
  assign userInterruptOut = s_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence hostWrCtrl2;
    wrCtrl2 && !masterIsUser;
  endsequence

  sequence userWrCtrl2;
    wrCtrl2 && masterIsUser;
  endsequence

  sequence serdesEvent;
    serdesIrq && !wrCause;
  endsequence

  a_um_lock_guard: assert property (hostWrCtrl2
      |=> $stable(userMasterBusLock))
    else $error("host changed user master lock");

  a_um_lock_set: assert property (userWrCtrl2
      ##0 busWdata[B_UM_LOCK] |=> userMasterBusLock)
    else $error("user master lock not set");

  // user master cannot move host lock
  a_hp_lock_guard: assert property (userWrCtrl2
      |=> $stable(hostPortBusLock))
    else $error("user master changed host lock");

  a_reconfig_req: assert property (wrCtrl2 &&
      (busWdata[B_UM_REQ] || busWdata[B_HP_REQ])
      |=> ##1 reconfigRequest)
    else $error("reconfig request missing");

  a_gsr_follow: assert property (wrCtrl2
      |=> globalSetReset == $past(busWdata[B_GSR]))
    else $error("global set reset wrong");

  a_option_bits: assert property (wrCtrl3
      |=> hostWriteParityCheck == $past(busWdata[B_PAR_CHK]) &&
          fabricPadAccessEnable == $past(busWdata[B_PAD_EN]))
    else $error("option bits wrong");

  a_pad_mirror: assert property (busRead &&
      hit(busAddr, ADDR_CFG_STAT)
      |=> busRvalid && busRdata[5:4] == $past({initPad, donePad}))
    else $error("pad mirror wrong");

  a_cause_irq: assert property (serdesEvent
      ##0 s_q.userEn[B_C_SERDES] ##1 s_q.userEn[B_C_SERDES]
      |=> userInterruptOut)
    else $error("enabled cause gave no interrupt");

  a_en_guard: assert property (wrUserEn && !masterIsUser
      |=> $stable(s_q.userEn))
    else $error("host wrote user enable");

  a_irq_quiet: assert property ((cause & s_q.userEn) == 8'h00
      |=> !userInterruptOut)
    else $error("spurious user interrupt");

  a_unmapped_zero: assert property (busRead &&
      hit(busAddr, 18'h0000B) |=> busRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // sysbus_ctrl_status_irq_regs

// File: shared/sysbus_regs_pkg.sv
// Functional notes
// - Control byte two bit 1 locks bus for user master; user master only.
// - Control byte two bit 2 locks bus for host port; host writes only.
// - Bits 4 or 5 force reconfiguration using mode pins caught after reset release.
// - Bit 6 enables bitstream daisy chaining through the host port.
// - Bit 7 drives global set/reset while it holds one.
// - Control byte three bit 5 enables host write parity checking.
// - Control byte three bit 7 lets fabric direct access drive host pads.
// - Status bits 0:1 give configuration error code, 00 none, 01 checksum.
// - Status bits 2 and 3 mirror the init and done pad levels.
// - Status bit 4 flags lost initialization data during configuration.
// - Status bits 5:6 capture first bus error; its address is stored too.
// - Status bit 7 flags readback address out of range.
// - Transfer status bits 0:1 report configuration write size code.
// - Bits 2 and 3 flag bad block RAM and aux block initialization data.
// - Bit 6 reads one while readback data is pending.
// - Bit 7 reads one when configuration data register can take a word.
// - Cause bits latch serdes, host, master, slave, user requests; W1C.
// - Cause bit 3 sets when the error code changes during configuration.
// - Cause bit 4 sets on configuration data request; write one clears it.
// - Enable bits 1 to 7 gate cause to user interrupt; user master only.
// - Bit 0 is the most significant bit; reset values are zero.
package sysbus_regs_pkg;
  localparam int ADDR_W = 18;
  localparam int MODE_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 18'h00009;
  localparam logic [ADDR_W-1:0] ADDR_CTRL3 = 18'h0000A;
  localparam logic [ADDR_W-1:0] ADDR_CFG_STAT = 18'h0000C;
  localparam logic [ADDR_W-1:0] ADDR_XFER_STAT = 18'h0000D;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = 18'h00010;
  localparam logic [ADDR_W-1:0] ADDR_USER_EN = 18'h00012;
  // Vector index = 7 - register bit number, bit 0 is MSB
  localparam int B_UM_LOCK = 6;
  localparam int B_HP_LOCK = 5;
  localparam int B_UM_REQ = 3;
  localparam int B_HP_REQ = 2;
  localparam int B_CHAIN = 1;
  localparam int B_GSR = 0;
  localparam int B_PAR_CHK = 2;
  localparam int B_PAD_EN = 0;
  localparam int B_C_SERDES = 6;
  localparam int B_C_HOST = 5;
  localparam int B_C_CFGERR = 4;
  localparam int B_C_CFGDATA = 3;
  localparam int B_C_UMASTER = 2;
  localparam int B_C_USLAVE = 1;
  localparam int B_C_USER = 0;
  localparam logic [7:0] CTRL2_ANY_MASK = 8'h0F;
  localparam logic [7:0] CTRL2_UM_MASK = 8'h40;
  localparam logic [7:0] CTRL2_HP_MASK = 8'h20;
  localparam logic [7:0] CTRL3_MASK = 8'h05;
  localparam logic [7:0] USER_EN_MASK = 8'h7F;
  localparam logic [7:0] CAUSE_MASK = 8'h7F;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
endpackage

// File: rtl/sticky_flags.sv
`timescale 1ns/1ps
module sticky_flags
  import sysbus_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] setFlags,
  input wire logic [WIDTH-1:0] clearFlags,
  output logic [WIDTH-1:0] flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } flag_state_t;

  flag_state_t s_q;
  flag_state_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < WIDTH; i++) begin
      s_d.flags[i] = setFlags[i] | (s_q.flags[i] & ~clearFlags[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;
endmodule // sticky_flags

// File: verification/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model
  import sysbus_regs_pkg::*;
(
  input wire logic clk,
  input wire logic busRvalid,
  input wire logic [7:0] busRdata,
  output logic busWrite,
  output logic busRead,
  output logic masterIsUser,
  output logic [ADDR_W-1:0] busAddr,
  output logic [7:0] busWdata
);
  initial begin
    busWrite = 1'b0;
    busRead = 1'b0;
    masterIsUser = 1'b0;
    busAddr = '0;
    busWdata = 8'h00;
  end
  // One byte access, optional idle gap first
  task automatic access(input logic u, input logic w,
      input logic [ADDR_W-1:0] a, input logic [7:0] d, input int gap,
      output logic [7:0] q, output logic v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    masterIsUser <= u;
    busAddr <= a;
    busWdata <= (a == ADDR_CTRL3) ? (d & 8'hFD) : d;
    busWrite <= w;
    busRead <= ~w;
    @(posedge clk);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    masterIsUser <= ~u;
    busAddr <= ~a;
    busWdata <= ~d;
    #1;
    q = busRdata;
    v = busRvalid;
  endtask
endmodule // bus_master_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import sysbus_regs_pkg::*;
;
  logic clk, rst, busWrite, busRead, masterIsUser, busRvalid, v;
  logic [ADDR_W-1:0] busAddr;
  logic [7:0] busWdata, busRdata, q, ctl;
  logic [MODE_W-1:0] modePins, reconfigMode;
  logic configuring, initPad, donePad, lost, rbErr, blkErr, auxErr;
  logic rbPend, wrRdy, umLock, hpLock, reqOut, chainEn, gsr, parChk;
  logic padEn, irqOut;
  logic [1:0] errCode, busErr, wrSize, beQ;
  logic [31:0] errAddr, firstBusErrAddr, eaQ, rnd, g;
  logic [6:0] irqSrc;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed, i;

  bus_master_model mst (.clk(clk), .busRvalid(busRvalid),
    .busRdata(busRdata), .busWrite(busWrite), .busRead(busRead),
    .masterIsUser(masterIsUser), .busAddr(busAddr), .busWdata(busWdata));

  sysbus_ctrl_status_irq_regs DUT (.clk(clk), .rst(rst),
    .busWrite(busWrite), .busRead(busRead), .masterIsUser(masterIsUser),
    .busAddr(busAddr), .busWdata(busWdata), .modePins(modePins),
    .configuring(configuring), .cfgErrCode(errCode), .initPad(initPad),
    .donePad(donePad), .cfgDataLost(lost), .cfgBusErr(busErr),
    .cfgBusErrAddr(errAddr), .readbackRangeError(rbErr),
    .cfgWriteSize(wrSize), .blockRamInitError(blkErr),
    .auxBlockInitError(auxErr), .readbackPending(rbPend),
    .cfgWriteReady(wrRdy), .serdesIrq(irqSrc[6]), .hostPortIrq(irqSrc[5]),
    .cfgDataReq(irqSrc[3]), .userMasterIrq(irqSrc[2]),
    .userSlaveIrq(irqSrc[1]), .userInterruptIn(irqSrc[0]),
    .busRdata(busRdata), .busRvalid(busRvalid), .userMasterBusLock(umLock),
    .hostPortBusLock(hpLock), .reconfigRequest(reqOut),
    .reconfigMode(reconfigMode), .chainConfigEnable(chainEn),
    .globalSetReset(gsr), .hostWriteParityCheck(parChk),
    .fabricPadAccessEnable(padEn), .firstBusErrAddr(firstBusErrAddr),
    .userInterruptOut(irqOut));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic u, input logic [ADDR_W-1:0] a,
      input logic [7:0] d);
    g = $random(seed);
    mst.access(u, 1'b1, a, d, int'(g[1:0]) % 3, q, v);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    g = $random(seed);
    mst.access(g[2], 1'b0, a, 8'h00, int'(g[0]), q, v);
    chk({v, q}, {1'b1, e});
  endtask

  // Writable mask depends on which master writes
  function automatic logic [7:0] ctl2(input logic [7:0] old,
      input logic [7:0] d, input logic u);
    logic [7:0] m;
    m = CTRL2_ANY_MASK | (u ? CTRL2_UM_MASK : CTRL2_HP_MASK);
    return (d & m) | (old & ~m & 8'h60);
  endfunction

  initial begin
    seed = 25066;
    rst = 1'b1;
    modePins = 3'h5;
    configuring = 1'b0;
    {errCode, initPad, donePad, lost, busErr, rbErr} = '0;
    {wrSize, blkErr, auxErr, rbPend, wrRdy, irqSrc} = '0;
    errAddr = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    modePins <= 3'h2;
    rdc(ADDR_CTRL2, 8'h00);
    rdc(ADDR_CAUSE, 8'h00);
    rdc(ADDR_USER_EN, 8'h00);
    ctl = 8'h00;
    for (i = 0; i < 14; i++) begin
      rnd = $random(seed);
      wr(rnd[8], ADDR_CTRL2, rnd[7:0]);
      ctl = ctl2(ctl, rnd[7:0], rnd[8]);
      rdc(ADDR_CTRL2, ctl);
      chk({umLock, hpLock, reqOut, chainEn, gsr}, {ctl[6:5],
        ctl[3] | ctl[2], ctl[1:0]});
    end
    wr(1'b1, ADDR_CTRL2, 8'h08);
    chk(reqOut, 1'b1);
    chk(reconfigMode, 3'h5);
    wr(1'b1, ADDR_CTRL2, 8'h00);
    chk(reqOut, 1'b0);
    for (i = 0; i < 6; i++) begin
      rnd = $random(seed);
      wr(rnd[8], ADDR_CTRL3, rnd[7:0]);
      rdc(ADDR_CTRL3, rnd[7:0] & 8'h05);
      chk({parChk, padEn}, {rnd[2], rnd[0]});
    end
    wr(1'b0, 18'h0000B, 8'hFF);
    rdc(18'h0000B, 8'h00);
    beQ = 2'h0;
    eaQ = 32'h0000_0000;
    for (i = 0; i < 8; i++) begin
      rnd = $random(seed);
      @(posedge clk);
      {errCode, initPad, donePad, lost, rbErr} <= rnd[5:0];
      {wrSize, blkErr, auxErr, rbPend, wrRdy} <= rnd[11:6];
      busErr <= (i == 3 || i == 6) ? (rnd[13:12] | 2'h1) : 2'h0;
      errAddr <= rnd ^ 32'h5A5A_0000;
      if (i == 3) begin
        beQ = rnd[13:12] | 2'h1;
        eaQ = rnd ^ 32'h5A5A_0000;
      end
      rdc(ADDR_CFG_STAT, {rnd[5:1], beQ, rnd[0]});
      rdc(ADDR_XFER_STAT, {rnd[11:8], 2'h0, rnd[7:6]});
      chk(firstBusErrAddr, eaQ);
    end
    wr(1'b1, ADDR_USER_EN, 8'hFF);
    wr(1'b0, ADDR_USER_EN, 8'h00);
    rdc(ADDR_USER_EN, 8'h7F);
    for (i = 0; i < 7; i++) begin
      @(posedge clk);
      irqSrc <= 7'h01 << i;
      configuring <= (i == 4);
      errCode <= errCode ^ {1'b0, i == 4};
      @(posedge clk);
      irqSrc <= 7'h00;
      configuring <= 1'b0;
      rdc(ADDR_CAUSE, 8'h01 << i);
      chk(irqOut, 1'b1);
      wr(1'b0, ADDR_CAUSE, 8'h01 << i);
      rdc(ADDR_CAUSE, 8'h00);
      chk(irqOut, 1'b0);
    end
    wr(1'b1, ADDR_USER_EN, 8'h3F);
    @(posedge clk);
    irqSrc <= 7'h40;
    @(posedge clk);
    irqSrc <= 7'h00;
    rdc(ADDR_CAUSE, 8'h40);
    chk(irqOut, 1'b0);
    summarize();
  end
endmodule // tb_top
